//--- rtl/rsrm_decode.sv
// remap address decoder for the bottom of the memory map
`timescale 1ns/10ps
module rsrm_decode
(
  input wire logic [31:0] addr,
  input wire logic remap,
  output logic sel_flash,
  output logic sel_sram,
  output logic in_vec
);
  wire logic in_mirror;
  assign in_mirror = addr < rsrm_pkg::MIRROR_SIZE;
  assign in_vec = (addr >= rsrm_pkg::VEC_BASE) && (addr < rsrm_pkg::VEC_END);
  assign sel_sram = in_mirror && remap;
  assign sel_flash = in_mirror && !remap;
endmodule

//--- rtl/rsrm_pkg.sv
// package: constants for the reset source and memory remap block
package rsrm_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] REMAP_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] CLEAR_OFS = 4'h8;
  localparam logic [3:0] IRQ_STAT_OFS = 4'hc;
  localparam logic [3:0] IRQ_MASK_OFS = 4'he;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int REMAP_BIT = 0;
  localparam int POR_BIT = 0;
  localparam int WDT_BIT = 1;
  localparam int SWR_BIT = 2;
  localparam int IRQ_POR_BIT = 0;
  localparam int IRQ_WDT_BIT = 1;
  localparam int IRQ_SWR_BIT = 2;
  localparam int IRQ_BADCLR_BIT = 3;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [3:0] IRQ_RST = 4'h0;
  // ----------------------------------------
  // memory map
  // ----------------------------------------
  localparam logic [31:0] VEC_BASE = 32'h00000000;
  localparam logic [31:0] VEC_END = 32'h00000020;
  localparam logic [31:0] MIRROR_SIZE = 32'h00010000;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int RST_PULSE_NS = 100;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CONFIG_NS = 500;
  localparam int CONFIG_CYC = (CONFIG_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {RSRM_RUN, RSRM_HOLD, RSRM_CONFIG} rsrm_boot_t;
endpackage

//--- rtl/rsrm_top.sv
// reset source recorder and memory remap with avalon slave
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module rsrm_top
(
  input wire logic clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // reset sources and boot mode pin
  input wire logic por_event,
  input wire logic wdt_timeout,
  input wire logic ext_reset_req,
  input wire logic boot_mode_pin,
  // core side
  input wire logic [31:0] core_addr,
  output logic sel_flash_q,
  output logic sel_sram_q,
  output logic vec_hit_q,
  output logic sys_reset_q,
  output logic core_run_q,
  output logic [31:0] core_pc_q,
  output logic irq_q
);
  // ----------------------------------------
  // local registers and wires
  // ----------------------------------------
  logic remap_q;
  logic [2:0] status_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic ack_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] cnt_q;
  rsrm_pkg::rsrm_boot_t state_q;
  wire logic sel_flash_w;
  wire logic sel_sram_w;
  wire logic in_vec_w;
  wire logic req;
  wire logic wr_go;
  wire logic rd_go;
  wire logic wr_remap;
  wire logic wr_status;
  wire logic wr_clear;
  wire logic wr_irqs;
  wire logic wr_mask;
  wire logic lane0;
  wire logic [2:0] clr_bits;
  wire logic bad_clear;
  wire logic sw_force;
  wire logic any_reset;
  wire logic [3:0] events;
  wire logic [31:0] rd_mux;
  wire logic [31:0] status_rd;
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  assign req = (avs_read || avs_write) && !ack_q;
  assign wr_go = avs_write && !ack_q;
  assign rd_go = avs_read && !ack_q;
  assign lane0 = avs_byteenable[0];
  assign wr_remap = wr_go && lane0 && (avs_address == rsrm_pkg::REMAP_OFS);
  assign wr_status = wr_go && lane0 && (avs_address == rsrm_pkg::STATUS_OFS);
  assign wr_clear = wr_go && lane0 && (avs_address == rsrm_pkg::CLEAR_OFS);
  assign wr_irqs = wr_go && lane0 && (avs_address == rsrm_pkg::IRQ_STAT_OFS);
  assign wr_mask = wr_go && lane0 && (avs_address == rsrm_pkg::IRQ_MASK_OFS);
  assign clr_bits = wr_clear ? avs_writedata[2:0] : 3'h0;
  assign bad_clear = wr_clear && ((status_q & ~avs_writedata[2:0]) != 3'h0);
  assign sw_force = wr_status && avs_writedata[rsrm_pkg::SWR_BIT];
  assign any_reset = por_event || wdt_timeout || ext_reset_req || sw_force || bad_clear;
  assign events = {bad_clear, sw_force, wdt_timeout, por_event};
  assign status_rd = {29'h0, status_q};
  assign rd_mux = (avs_address == rsrm_pkg::REMAP_OFS) ? {31'h0, remap_q} :
                  (avs_address == rsrm_pkg::STATUS_OFS) ? status_rd :
                  (avs_address == rsrm_pkg::IRQ_STAT_OFS) ? {28'h0, irq_stat_q} :
                  (avs_address == rsrm_pkg::IRQ_MASK_OFS) ? {28'h0, irq_mask_q} :
                  32'h0;
  // ----------------------------------------
  // bus handshake: one wait cycle per access
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end
    else
    begin
      ack_q <= req;
      wait_q <= !req;
      if (rd_go)
        rdata_q <= rd_mux;
    end
  end
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  // ----------------------------------------
  // remap bit and reset status
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      remap_q <= 1'b0;
      status_q <= rsrm_pkg::STATUS_RST[2:0];
    end
    else
    begin
      if (any_reset)
        remap_q <= 1'b0;
      else if (wr_remap)
        remap_q <= avs_writedata[rsrm_pkg::REMAP_BIT];
      status_q[rsrm_pkg::POR_BIT] <= por_event || (status_q[rsrm_pkg::POR_BIT] && !clr_bits[0]);
      status_q[rsrm_pkg::WDT_BIT] <= wdt_timeout || (status_q[rsrm_pkg::WDT_BIT] && !clr_bits[1]);
      status_q[rsrm_pkg::SWR_BIT] <= sw_force || (status_q[rsrm_pkg::SWR_BIT] && !clr_bits[2]);
    end
  end
  // ----------------------------------------
  // interrupt status, write one to clear
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_stat_q <= rsrm_pkg::IRQ_RST;
      irq_mask_q <= rsrm_pkg::IRQ_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= events | (irq_stat_q & ~(wr_irqs ? avs_writedata[3:0] : 4'h0));
      if (wr_mask)
        irq_mask_q <= avs_writedata[3:0];
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end
  // ----------------------------------------
  // reset pulse and boot sequence
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= rsrm_pkg::RSRM_HOLD;
      cnt_q <= 8'h0;
      sys_reset_q <= 1'b1;
      core_run_q <= 1'b0;
      core_pc_q <= 32'h0;
    end
    else
    begin
      case (state_q)
        rsrm_pkg::RSRM_RUN:
        begin
          if (any_reset)
          begin
            state_q <= rsrm_pkg::RSRM_HOLD;
            cnt_q <= 8'h0;
            sys_reset_q <= 1'b1;
            core_run_q <= 1'b0;
          end
        end
        rsrm_pkg::RSRM_HOLD:
        begin
          cnt_q <= cnt_q + 8'h1;
          if (cnt_q == 8'(rsrm_pkg::RST_PULSE_CYC - 1))
          begin
            sys_reset_q <= 1'b0;
            cnt_q <= 8'h0;
            state_q <= rsrm_pkg::RSRM_CONFIG;
          end
        end
        rsrm_pkg::RSRM_CONFIG:
        begin
          cnt_q <= cnt_q + 8'h1;
          if (any_reset)
          begin
            state_q <= rsrm_pkg::RSRM_HOLD;
            cnt_q <= 8'h0;
            sys_reset_q <= 1'b1;
          end
          else if (boot_mode_pin && cnt_q == 8'(rsrm_pkg::CONFIG_CYC - 1))
          begin
            core_pc_q <= rsrm_pkg::VEC_BASE;
            core_run_q <= 1'b1;
            state_q <= rsrm_pkg::RSRM_RUN;
          end
        end
        default:
          state_q <= rsrm_pkg::RSRM_HOLD;
      endcase
    end
  end
  // ----------------------------------------
  // memory select at the bottom of the map
  // ----------------------------------------
  rsrm_decode u_dec
  (
    .addr(core_addr),
    .remap(remap_q),
    .sel_flash(sel_flash_w),
    .sel_sram(sel_sram_w),
    .in_vec(in_vec_w)
  );
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sel_flash_q <= 1'b0;
      sel_sram_q <= 1'b0;
      vec_hit_q <= 1'b0;
    end
    else
    begin
      sel_flash_q <= sel_flash_w;
      sel_sram_q <= sel_sram_w;
      vec_hit_q <= in_vec_w;
    end
  end
endmodule

//--- testbench/rsrm_asserts.sv
// checker: port assertions for the remap block
`timescale 1ns/10ps
module rsrm_asserts
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic boot_mode_pin,
  input wire logic [31:0] core_addr,
  input wire logic sel_flash_q,
  input wire logic sel_sram_q,
  input wire logic vec_hit_q,
  input wire logic sys_reset_q,
  input wire logic core_run_q,
  input wire logic [31:0] core_pc_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  vec_region_a: assert property ($past(nrst) |-> vec_hit_q == ($past(core_addr) < 32'h20))
    else $error("vector hit wrong");
  mirror_span_a: assert property ($past(nrst) |-> (sel_flash_q || sel_sram_q) == ($past(core_addr) < 32'h10000))
    else $error("mirror select wrong");
  one_memory_a: assert property (!(sel_flash_q && sel_sram_q))
    else $error("both memories selected");
  reset_flash_a: assert property ($past(sys_reset_q, 2) && $past(sys_reset_q) |-> !sel_sram_q)
    else $error("sram mirrored in reset");
  hold_len_a: assert property ($rose(sys_reset_q) |=> sys_reset_q[*8])
    else $error("reset pulse short");
  config_wait_a: assert property ($fell(sys_reset_q) |-> (!core_run_q)[*8])
    else $error("config skipped");
  run_vector_a: assert property (core_run_q |-> core_pc_q == 32'h0 && !sys_reset_q)
    else $error("run vector wrong");
  boot_pin_a: assert property ($rose(core_run_q) |-> boot_mode_pin)
    else $error("run without normal boot");
  bus_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer");
  ack_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
endmodule

//--- testbench/rsrm_sources.sv
// partner: on-chip reset sources pulsing one cycle
`timescale 1ns/10ps
module rsrm_sources
(
  input wire logic clk,
  input wire logic [2:0] fire,
  output logic por_event,
  output logic wdt_timeout,
  output logic ext_reset_req
);
  logic [2:0] prev_q;
  always_ff @(posedge clk)
  begin
    prev_q <= fire;
    por_event <= fire[0] & !prev_q[0];
    wdt_timeout <= fire[1] & !prev_q[1];
    ext_reset_req <= fire[2] & !prev_q[2];
  end
endmodule

//--- testbench/test_reset_source_and_memory_remap.sv
// testbench: remap and reset source recorder
`timescale 1ns/10ps
module test_reset_source_and_memory_remap;
  logic clk, nrst, avs_read, avs_write, boot_mode_pin, avs_waitrequest;
  logic por_event, wdt_timeout, ext_reset_req, sel_flash_q, sel_sram_q, vec_hit_q, sys_reset_q, core_run_q, irq_q;
  logic [3:0] avs_address;
  logic [2:0] fire;
  logic [31:0] avs_writedata, avs_readdata, core_addr, core_pc_q, rdat;
  int fail_count = 0;
  int checked = 0;
  rsrm_top i_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .por_event(por_event), .wdt_timeout(wdt_timeout),
    .ext_reset_req(ext_reset_req), .boot_mode_pin(boot_mode_pin), .core_addr(core_addr),
    .sel_flash_q(sel_flash_q), .sel_sram_q(sel_sram_q), .vec_hit_q(vec_hit_q), .sys_reset_q(sys_reset_q),
    .core_run_q(core_run_q), .core_pc_q(core_pc_q), .irq_q(irq_q));
  rsrm_sources i_src (.clk(clk), .fire(fire), .por_event(por_event), .wdt_timeout(wdt_timeout),
    .ext_reset_req(ext_reset_req));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude;
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one bus transfer, held until waitrequest is low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("readdata", e, rdat);
  endtask
  task automatic look(input logic [31:0] a, input logic f, input logic v);
    @(posedge clk);
    core_addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk("sel_flash_q", {31'h0, f}, {31'h0, sel_flash_q});
    chk("sel_sram_q", {31'h0, !f}, {31'h0, sel_sram_q});
    chk("vec_hit_q", {31'h0, v}, {31'h0, vec_hit_q});
  endtask
  task automatic wait_run;
    int n;
    n = 0;
    while (core_run_q !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk("core_run_q", 32'h1, {31'h0, core_run_q});
  endtask
  // fire sources, then expect a reset pulse and a fresh boot
  task automatic kick(input logic [2:0] f);
    int n;
    fire <= f;
    @(posedge clk);
    fire <= 3'h0;
    n = 0;
    while (sys_reset_q !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      n++;
    end
    chk("sys_reset_q", 32'h1, {31'h0, sys_reset_q});
    wait_run;
  endtask
  initial
  begin
    #50000;
    fail_count++;
    conclude;
  end
  initial
  begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    boot_mode_pin = 1'b1;
    core_addr = 32'h0;
    fire = 3'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    wait_run;
    chk("core_pc_q", 32'h0, core_pc_q);
    rd(4'h4, 32'h0);
    rd(4'h0, 32'h0);
    look(32'h10, 1'b1, 1'b1);
    bus(1'b1, 4'h0, 32'h1);
    rd(4'h0, 32'h1);
    look(32'h1c, 1'b0, 1'b1);
    look(32'h20, 1'b0, 1'b0);
    bus(1'b1, 4'h0, 32'h0);
    look(32'h4, 1'b1, 1'b1);
    bus(1'b1, 4'h0, 32'h1);
    kick(3'h1);
    rd(4'h0, 32'h0);
    kick(3'h2);
    rd(4'h4, 32'h3);
    bus(1'b1, 4'h8, 32'h1);
    kick(3'h0);
    rd(4'h4, 32'h2);
    bus(1'b1, 4'h8, 32'h2);
    rd(4'h4, 32'h0);
    bus(1'b1, 4'h4, 32'hff);
    kick(3'h0);
    rd(4'h4, 32'h4);
    bus(1'b1, 4'h8, 32'h4);
    kick(3'h4);
    rd(4'h4, 32'h0);
    rd(4'hc, 32'hf);
    bus(1'b1, 4'hc, 32'hf);
    rd(4'hc, 32'h0);
    rd(4'h2, 32'h0);
    bus(1'b1, 4'h8, 32'h0);
    bus(1'b1, 4'he, 32'hf);
    rd(4'he, 32'hf);
    bus(1'b1, 4'h4, 32'h4);
    wait_run;
    @(negedge clk);
    chk("irq_q", 32'h1, {31'h0, irq_q});
    bus(1'b1, 4'hc, 32'hf);
    @(negedge clk);
    chk("irq_q", 32'h0, {31'h0, irq_q});
    boot_mode_pin <= 1'b0;
    bus(1'b1, 4'h4, 32'h4);
    repeat (200) @(posedge clk);
    chk("core_run_q", 32'h0, {31'h0, core_run_q});
    conclude;
  end
endmodule
bind rsrm_top rsrm_asserts i_chk (.clk(clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .boot_mode_pin(boot_mode_pin), .core_addr(core_addr),
  .sel_flash_q(sel_flash_q), .sel_sram_q(sel_sram_q), .vec_hit_q(vec_hit_q), .sys_reset_q(sys_reset_q),
  .core_run_q(core_run_q), .core_pc_q(core_pc_q));
